// *** verilog/acp_map.vh ***
`ifndef ACP_MAP_VH
`define ACP_MAP_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ACP_REG_CTRL     12'h000
`define ACP_REG_PCR      12'h004
`define ACP_REG_SCR      12'h008
`define ACP_REG_CDVT     12'h00C
`define ACP_REG_MBS      12'h010
`define ACP_REG_LINE     12'h014
`define ACP_REG_STATUS   12'h018
`define ACP_REG_PASS     12'h01C
`define ACP_REG_TAG      12'h020
`define ACP_REG_DROP     12'h024
`define ACP_REG_BW       12'h028

// ****************************************************************
// Control fields and reset values
// ****************************************************************
`define ACP_CTRL_MODE_LSB   0
`define ACP_CTRL_MODE_MSB   2
`define ACP_CTRL_CBR_BIT    3
`define ACP_CTRL_PTYPE_LSB  4
`define ACP_CTRL_PTYPE_MSB  5
`define ACP_CTRL_UTIL_LSB   8
`define ACP_CTRL_UTIL_MSB   14
`define ACP_CTRL_RST        32'h0000_6405
`define ACP_LINE_RST        24'h05_8B_A0

// ****************************************************************
// Modes, port types and limits
// ****************************************************************
`define ACP_MODE_VBR1  3'h1
`define ACP_MODE_VBR2  3'h2
`define ACP_MODE_VBR3  3'h3
`define ACP_MODE_PCR   3'h4
`define ACP_MODE_OFF   3'h5
`define ACP_PT_SLOW    2'h0
`define ACP_PT_MED     2'h1
`define ACP_PT_OPT     2'h2
`define ACP_MIN_SLOW   24'h00_0006
`define ACP_MIN_MED    24'h00_000C
`define ACP_MIN_OPT    24'h00_0032

// ****************************************************************
// Timing: GCRA time unit is one microsecond
// ****************************************************************
`define ACP_CLK_MHZ    25
`define ACP_TICK_NS    1000
`define ACP_TICK_CYC   ((`ACP_TICK_NS * `ACP_CLK_MHZ) / 1000)
`define ACP_US_PER_S   32'd1000000

`endif

// *** verilog/acp_gcra.v ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// One virtual-scheduling leaky bucket
// ****************************************************************
module acp_gcra (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        enable,
    input  wire        clear,
    input  wire [31:0] now,
    input  wire [31:0] incr,
    input  wire [31:0] limit,
    input  wire        test,
    input  wire        commit,
    output wire        conform
);
    reg  [31:0] tat_r;
    wire [31:0] late;

    // Time arithmetic is modular so the microsecond counter may wrap.
    assign late = tat_r - now;
    assign conform = !enable || tat_r == 32'h0 || late[31] || late <= limit;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tat_r <= 32'h0;
        end else if (clear || !enable) begin
            tat_r <= 32'h0;
        end else if (test && commit) begin
            if (tat_r == 32'h0 || late[31])
                tat_r <= now + incr;
            else
                tat_r <= tat_r + incr;
        end
    end
endmodule // acp_gcra

`default_nettype wire

// *** verilog/acp_policer.v ***
`timescale 1ns/1ps
`default_nettype none
`include "acp_map.vh"

module acp_policer (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        cell_valid,
    input  wire        cell_clp,
    output wire        cell_ready,
    output reg         out_valid,
    output reg         out_clp,
    output reg         out_drop
);
    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    reg  [31:0] ctrl_r;
    reg  [23:0] pcr_r;
    reg  [23:0] scr_r;
    reg  [23:0] cdvt_r;
    reg  [23:0] mbs_r;
    reg  [23:0] line_r;
    reg  [31:0] pass_r;
    reg  [31:0] tag_r;
    reg  [31:0] drop_r;
    reg         bad_r;

    wire [2:0]  mode  = ctrl_r[`ACP_CTRL_MODE_MSB:`ACP_CTRL_MODE_LSB];
    wire        cbr   = ctrl_r[`ACP_CTRL_CBR_BIT];
    wire [1:0]  ptype = ctrl_r[`ACP_CTRL_PTYPE_MSB:`ACP_CTRL_PTYPE_LSB];
    wire [6:0]  util  = ctrl_r[`ACP_CTRL_UTIL_MSB:`ACP_CTRL_UTIL_LSB];

    // Minimum rate for a port type, used in write checks and status.
    // six, twelve or fifty cps floor by port type
    function [23:0] min_rate;
        input [1:0] pt;
        begin
            case (pt)
                `ACP_PT_SLOW: min_rate = `ACP_MIN_SLOW;
                `ACP_PT_MED:  min_rate = `ACP_MIN_MED;
                default:      min_rate = `ACP_MIN_OPT;
            endcase
        end
    endfunction

    // A mode is legal if it is 1..5 and, on constant rate, only 4 or 5.
    function mode_ok;
        input [2:0] m;
        input       c;
        begin
            if (c)
                mode_ok = (m == `ACP_MODE_PCR) || (m == `ACP_MODE_OFF);
            else
                mode_ok = (m >= `ACP_MODE_VBR1) && (m <= `ACP_MODE_OFF);
        end
    endfunction

    // A rate passes when within [port minimum, line rate]; the minimum
    // is waived while policing is off.
    function rate_ok;
        input [23:0] r;
        input [2:0]  m;
        input [1:0]  pt;
        input [23:0] lr;
        begin
            rate_ok = (r <= lr) && (r != 24'h0) && ((m == `ACP_MODE_OFF) || (r >= min_rate(pt)));
        end
    endfunction

    // ****************************************************************
    // APB slave, zero wait states
    // ****************************************************************
    wire wr = psel && penable && pwrite;
    wire [2:0]  wmode = pwdata[`ACP_CTRL_MODE_MSB:`ACP_CTRL_MODE_LSB];
    wire        wcbr  = pwdata[`ACP_CTRL_CBR_BIT];
    wire [1:0]  wpt   = pwdata[`ACP_CTRL_PTYPE_MSB:`ACP_CTRL_PTYPE_LSB];
    reg         err;

    assign pready  = 1'b1;
    assign pslverr = psel && penable && err;

    // Refused writes leave the register unchanged and raise pslverr.
    always @* begin
        err = 1'b0;
        case (paddr)
            `ACP_REG_CTRL: err = pwrite && (!mode_ok(wmode, wcbr) || pwdata[14:8] > 7'd100
                                 || (wmode != `ACP_MODE_OFF && (pcr_r < min_rate(wpt) || scr_r < min_rate(wpt))));
            // low rates only with policing off
            `ACP_REG_PCR:  err = pwrite && !rate_ok(pwdata[23:0], mode, ptype, line_r);
            `ACP_REG_SCR:  err = pwrite && !rate_ok(pwdata[23:0], mode, ptype, line_r);
            `ACP_REG_CDVT, `ACP_REG_MBS, `ACP_REG_LINE, `ACP_REG_STATUS,
            `ACP_REG_PASS, `ACP_REG_TAG, `ACP_REG_DROP, `ACP_REG_BW: err = 1'b0;
            default:       err = 1'b1;
        endcase
    end

    // Config writes take effect at the access-phase edge.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `ACP_CTRL_RST;
            pcr_r  <= `ACP_LINE_RST;
            scr_r  <= `ACP_LINE_RST;
            cdvt_r <= 24'h0;
            mbs_r  <= 24'h1;
            line_r <= `ACP_LINE_RST;
        end else if (wr && !err) begin
            case (paddr)
                `ACP_REG_CTRL: ctrl_r <= {17'h0, pwdata[14:8], 2'b00, pwdata[5:0]};
                `ACP_REG_PCR:  pcr_r  <= pwdata[23:0];
                `ACP_REG_SCR:  scr_r  <= pwdata[23:0];
                `ACP_REG_CDVT: cdvt_r <= pwdata[23:0];
                `ACP_REG_MBS:  mbs_r  <= (pwdata[23:0] == 24'h0) ? 24'h1 : pwdata[23:0];
                `ACP_REG_LINE: line_r <= pwdata[23:0];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Increments: divider computes 1e6 / rate in microseconds
    // ****************************************************************
    reg  [31:0] ip_r;
    reg  [31:0] is_r;
    reg  [31:0] bt_r;
    reg  [31:0] quo_r;
    reg  [31:0] rem_r;
    reg  [5:0]  dcnt_r;
    reg  [1:0]  dsel_r;
    reg  [23:0] dsor;
    wire        busy = dcnt_r != 6'd0;
    wire [32:0] rem_sh = {rem_r, quo_r[31]};
    wire        sub = rem_sh >= {9'h0, dsor};

    // Cycle the divider continuously over both rates so new values land
    // within about a hundred cycles; a serial divider keeps area small.
    // The increment is truncated, not rounded, so its error grows as the rate rises.
    always @* begin
        case (dsel_r)
            2'd0:    dsor = pcr_r;
            default: dsor = scr_r;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quo_r  <= 32'h0;
            rem_r  <= 32'h0;
            dcnt_r <= 6'd0;
            dsel_r <= 2'd0;
            ip_r   <= 32'h1;
            is_r   <= 32'h1;
        end else if (!busy) begin
            quo_r  <= `ACP_US_PER_S;
            rem_r  <= 32'h0;
            dcnt_r <= 6'd32;
        end else begin
            quo_r  <= {quo_r[30:0], sub};
            rem_r  <= sub ? (rem_sh[31:0] - {8'h0, dsor}) : rem_sh[31:0];
            dcnt_r <= dcnt_r - 6'd1;
            if (dcnt_r == 6'd1) begin
                if (dsel_r == 2'd0)
                    ip_r <= {quo_r[30:0], sub};
                else
                    is_r <= {quo_r[30:0], sub};
                dsel_r <= (dsel_r == 2'd0) ? 2'd1 : 2'd0;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            bt_r <= 32'h0;
        else if (is_r > ip_r)
            bt_r <= (mbs_r[15:0] - 16'h1) * (is_r - ip_r);
        else
            bt_r <= 32'h0;
    end

    // ****************************************************************
    // Microsecond time base
    // ****************************************************************
    reg [7:0]  tick_r;
    reg [31:0] now_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_r <= 8'h0;
            now_r  <= 32'h1;
        end else if ({24'h0, tick_r} == (`ACP_TICK_CYC - 1)) begin
            tick_r <= 8'h0;
            now_r  <= (now_r == 32'hFFFF_FFFF) ? 32'h1 : now_r + 32'h1;
        end else begin
            tick_r <= tick_r + 8'h1;
        end
    end

    // ****************************************************************
    // Bucket selection per mode
    // ****************************************************************
    reg p_en;
    reg s_en;
    reg s_clp0;
    reg s_tag;

    always @* begin
        p_en = 1'b0;
        s_en = 1'b0;
        s_clp0 = 1'b0;
        s_tag = 1'b0;
        case (mode)
            `ACP_MODE_VBR1: begin
                p_en = 1'b1;
                s_en = 1'b1;
            end
            `ACP_MODE_VBR2: begin
                p_en = 1'b1;
                s_en = 1'b1;
                s_clp0 = 1'b1;
            end
            `ACP_MODE_VBR3: begin
                p_en = 1'b1;
                s_en = 1'b1;
                s_clp0 = 1'b1;
                s_tag = 1'b1;
            end
            `ACP_MODE_PCR: p_en = 1'b1;
            default: ;
        endcase
    end

    // ****************************************************************
    // Cell path: one cell per cycle, result one cycle later
    // ****************************************************************
    wire busy_cfg = 1'b0;
    wire take   = cell_valid && !busy_cfg;
    wire p_ok;
    wire s_ok;
    wire s_test = take && s_en && (!s_clp0 || !cell_clp);
    // tagged cell counts as low priority
    wire tagit  = s_test && !s_ok && s_tag;
    wire dropc  = take && ((p_en && !p_ok) || (s_test && !s_ok && !s_tag));
    wire keep   = take && !dropc;
    wire cfgw   = wr && !err && (paddr == `ACP_REG_CTRL);

    assign cell_ready = 1'b1;

    acp_gcra u_peak (
        .pclk    (pclk),
        .presetn (presetn),
        .enable  (p_en),
        .clear   (cfgw),
        .now     (now_r),
        .incr    (ip_r),
        .limit   ({8'h0, cdvt_r}),
        .test    (take),
        .commit  (keep),
        .conform (p_ok)
    );

    acp_gcra u_sust (
        .pclk    (pclk),
        .presetn (presetn),
        .enable  (s_en),
        .clear   (cfgw),
        .now     (now_r),
        .incr    (is_r),
        .limit   (bt_r),
        .test    (s_test),
        .commit  (keep && !tagit),
        .conform (s_ok)
    );

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid <= 1'b0;
            out_clp   <= 1'b0;
            out_drop  <= 1'b0;
            pass_r    <= 32'h0;
            tag_r     <= 32'h0;
            drop_r    <= 32'h0;
        end else begin
            out_valid <= keep;
            out_clp   <= keep && (cell_clp || tagit);
            out_drop  <= dropc;
            if (keep)
                pass_r <= pass_r + 32'h1;
            if (tagit)
                tag_r <= tag_r + 32'h1;
            if (dropc)
                drop_r <= drop_r + 32'h1;
        end
    end

    // Status flags rate settings that fell out of range after a line-rate change.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            bad_r <= 1'b0;
        else
            bad_r <= !rate_ok(pcr_r, mode, ptype, line_r) || !rate_ok(scr_r, mode, ptype, line_r);
    end

    // ****************************************************************
    // Read mux
    // ****************************************************************
    // reserved bandwidth
    wire [31:0] bw = ({8'h0, pcr_r} * {25'h0, util}) / 32'd100;
    wire [23:0] min_cur = min_rate(ptype);

    always @* begin
        case (paddr)
            `ACP_REG_CTRL:   prdata = ctrl_r;
            `ACP_REG_PCR:    prdata = {8'h0, pcr_r};
            `ACP_REG_SCR:    prdata = {8'h0, scr_r};
            `ACP_REG_CDVT:   prdata = {8'h0, cdvt_r};
            `ACP_REG_MBS:    prdata = {8'h0, mbs_r};
            `ACP_REG_LINE:   prdata = {8'h0, line_r};
            `ACP_REG_STATUS: prdata = {22'h0, bad_r, busy, min_cur[7:0]};
            `ACP_REG_PASS:   prdata = pass_r;
            `ACP_REG_TAG:    prdata = tag_r;
            `ACP_REG_DROP:   prdata = drop_r;
            `ACP_REG_BW:     prdata = cbr ? bw : 32'h0;
            default:         prdata = 32'h0;
        endcase
    end
endmodule // acp_policer

`default_nettype wire

// *** verif/acp_policer_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "acp_map.vh"

// ****************************************************************
// Port checker for the cell policer
// ****************************************************************
module acp_policer_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        cell_valid,
    input wire logic        cell_clp,
    input wire logic        cell_ready,
    input wire logic        out_valid,
    input wire logic        out_clp,
    input wire logic        out_drop
);
    logic [2:0]  mode_r;
    logic [1:0]  pt_r;
    logic [23:0] line_r;

    // Write strobes seen in the access phase.
    wire logic        acc     = psel && penable && pwrite;
    wire logic        ctrl_wr = acc && (paddr == `ACP_REG_CTRL);
    wire logic        rate_wr = acc && (paddr == `ACP_REG_PCR || paddr == `ACP_REG_SCR);
    wire logic [23:0] min_w   = (pt_r == 2'h0) ? `ACP_MIN_SLOW : (pt_r == 2'h1) ? `ACP_MIN_MED : `ACP_MIN_OPT;

    // Shadow of accepted settings, so refusals can be judged against the live mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= 3'h5;
            pt_r   <= 2'h0;
            line_r <= `ACP_LINE_RST;
        end else if (ctrl_wr && !pslverr) begin
            mode_r <= pwdata[2:0];
            pt_r   <= pwdata[5:4];
        end else if (acc && !pslverr && paddr == `ACP_REG_LINE) begin
            line_r <= pwdata[23:0];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_ONE_ANSWER: assert property (cell_valid |=> out_valid != out_drop)
        else $error("offered cell not answered exactly once");
    AST_IDLE_QUIET: assert property (!cell_valid |=> !out_valid && !out_drop)
        else $error("answer without an offered cell");
    AST_CLP_KEPT: assert property (cell_valid && cell_clp |=> !out_valid || out_clp)
        else $error("low priority cell forwarded as high priority");
    AST_OFF_PASS: assert property (mode_r == 3'h5 && cell_valid |=> out_valid && out_clp == $past(cell_clp))
        else $error("cell not passed untouched with policing off");
    AST_NO_TAG: assert property ((mode_r == 3'h1 || mode_r == 3'h2 || mode_r == 3'h4) && cell_valid && !cell_clp
        |=> !(out_valid && out_clp))
        else $error("cell tagged in a mode without tagging");
    AST_BAD_MODE: assert property (ctrl_wr && (pwdata[2:0] == 3'h0 || pwdata[2:0] > 3'h5
        || (pwdata[3] && pwdata[2:0] < 3'h4)) |-> pslverr)
        else $error("illegal mode accepted");
    AST_UTIL: assert property (ctrl_wr && pwdata[14:8] > 7'h64 |-> pslverr)
        else $error("utilisation above one hundred accepted");
    AST_RATE_MAX: assert property (rate_wr && pwdata[23:0] > line_r |-> pslverr)
        else $error("rate above line rate accepted");
    AST_RATE_MIN: assert property (rate_wr && mode_r != 3'h5 && pwdata[23:0] < min_w |-> pslverr)
        else $error("rate below port minimum accepted while policing");
endmodule // acp_policer_checker

bind acp_policer acp_policer_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cell_valid(cell_valid),
    .cell_clp(cell_clp), .cell_ready(cell_ready), .out_valid(out_valid), .out_clp(out_clp), .out_drop(out_drop)
);

`default_nettype wire

// *** verif/acp_cell_src.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// User-side cell source
// ****************************************************************
module acp_cell_src (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       req,
    input  wire logic [3:0] req_n,
    input  wire logic       req_clp,
    input  wire logic [7:0] req_gap,
    input  wire logic       cell_ready,
    output var  logic       cell_valid,
    output var  logic       cell_clp
);
    logic [7:0] gap_r;
    logic [3:0] left_r;
    logic       clp_r;

    // A burst waits out its gap, then offers cells back to back; each is held until ready.
    // While a burst waits out its gap the priority line toggles, and it flips once as a burst ends, so a stale bit can never pass for a real one.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_r      <= 8'h00;
            left_r     <= 4'h0;
            clp_r      <= 1'b0;
            cell_valid <= 1'b0;
            cell_clp   <= 1'b1;
        end else if (req) begin
            gap_r  <= req_gap;
            left_r <= req_n;
            clp_r  <= req_clp;
        end else if (cell_valid && cell_ready && left_r == 4'h1) begin
            left_r     <= 4'h0;
            cell_valid <= 1'b0;
            cell_clp   <= ~cell_clp;
        end else if (cell_valid && cell_ready) begin
            left_r <= left_r - 4'h1;
        end else if (left_r != 4'h0 && gap_r != 8'h00) begin
            gap_r    <= gap_r - 8'h01;
            cell_clp <= ~cell_clp;
        end else if (left_r != 4'h0 && !cell_valid) begin
            cell_valid <= 1'b1;
            cell_clp   <= clp_r;
        end
    end
endmodule // acp_cell_src

`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "acp_map.vh"

// ****************************************************************
// Policer testbench
// ****************************************************************
module testbench;
    localparam logic [1:0] P0 = 2'b10;
    localparam logic [1:0] P1 = 2'b11;
    localparam logic [1:0] DR = 2'b01;
    localparam logic [6:0] ROWS [5] = '{{3'h1, 1'b0, 1'b1, DR}, {3'h1, 1'b1, 1'b0, P0},
        {3'h2, 1'b0, 1'b1, P1}, {3'h2, 1'b0, 1'b0, DR}, {3'h3, 1'b0, 1'b0, P1}};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic        cell_valid, cell_clp, cell_ready, out_valid, out_clp, out_drop, req, req_clp;
    logic [3:0]  req_n;
    logic [7:0]  req_gap;
    logic [1:0]  q [$];
    int          n_errors = 0;
    int          total_checks = 0;
    int          cyc = 0;

    acp_policer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cell_valid(cell_valid), .cell_clp(cell_clp), .cell_ready(cell_ready),
        .out_valid(out_valid), .out_clp(out_clp), .out_drop(out_drop));
    acp_cell_src u_src (.pclk(pclk), .presetn(presetn), .req(req), .req_n(req_n), .req_clp(req_clp),
        .req_gap(req_gap), .cell_ready(cell_ready), .cell_valid(cell_valid), .cell_clp(cell_clp));

    // Clock at 25 MHz.
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Outputs stand from edge to edge, so the falling edge sees them settled.
    always @(negedge pclk) begin
        if (out_valid === 1'b1) q.push_back({1'b1, out_clp});
        else if (out_drop === 1'b1) q.push_back(DR);
    end

    // Hang guard; the whole run needs well under this many cycles.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // One APB transfer; the request is held until pready is seen at a rising edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        check("pslverr", {31'h0, rerr}, {31'h0, e});
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check("register", rdata, exp);
    endtask

    // The divider cycles without pause, so its busy bit says little; wait out three passes instead.
    task automatic idle;
        repeat (100) @(posedge pclk);
        apb(1'b0, `ACP_REG_STATUS, 32'h0);
        check("rate status", {31'h0, rdata[9]}, 32'h0);
    endtask

    // Send a burst and compare each verdict; the first cell's code is in ex[5:4].
    task automatic cells(input logic [3:0] n, input logic clp, input logic [7:0] gap, input logic [5:0] ex);
        int t;
        t = 0;
        q.delete();
        req     <= 1'b1;
        req_n   <= n;
        req_clp <= clp;
        req_gap <= gap;
        @(posedge pclk);
        req <= 1'b0;
        while (q.size() < int'(n) && t < 400) begin
            @(posedge pclk);
            t++;
        end
        for (int i = 0; i < int'(n); i++)
            check("cell", {30'h0, (q.size() > i) ? q[i] : 2'bxx}, {30'h0, ex[(2 - i) * 2 +: 2]});
    endtask

    function automatic logic [31:0] ctl(input logic [2:0] m, input logic c, input logic [1:0] pt,
                                        input logic [6:0] u);
        ctl = {17'h0, u, 2'b00, pt, c, m};
    endfunction

    // Main sequence.
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        req = 1'b0;
        req_n = 4'h0;
        req_clp = 1'b0;
        req_gap = 8'h00;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(`ACP_REG_CTRL, `ACP_CTRL_RST);
        rchk(`ACP_REG_PCR, {8'h00, `ACP_LINE_RST});
        rchk(`ACP_REG_BW, 32'h0);
        idle();
        cells(4'h3, 1'b1, 8'h00, {P1, P1, P1});
        for (int p = 0; p < 3; p++) begin
            wr(`ACP_REG_CTRL, ctl(3'h5, 1'b0, p[1:0], 7'h64), 1'b0);
            apb(1'b0, `ACP_REG_STATUS, 32'h0);
            check("min rate", {24'h0, rdata[7:0]}, {8'h00, (p == 0) ? `ACP_MIN_SLOW :
                (p == 1) ? `ACP_MIN_MED : `ACP_MIN_OPT});
        end
        wr(`ACP_REG_CTRL, ctl(3'h5, 1'b0, 2'h0, 7'h64), 1'b0);
        wr(`ACP_REG_CTRL, ctl(3'h1, 1'b1, 2'h0, 7'h64), 1'b1);
        wr(`ACP_REG_CTRL, ctl(3'h0, 1'b0, 2'h0, 7'h64), 1'b1);
        wr(`ACP_REG_CTRL, ctl(3'h4, 1'b0, 2'h0, 7'h65), 1'b1);
        rchk(`ACP_REG_CTRL, `ACP_CTRL_RST);
        wr(`ACP_REG_PCR, {8'h00, `ACP_LINE_RST} + 32'h1, 1'b1);
        wr(`ACP_REG_PCR, 32'h0000_0005, 1'b0);
        wr(`ACP_REG_CTRL, ctl(3'h1, 1'b0, 2'h0, 7'h64), 1'b1);
        wr(`ACP_REG_PCR, 32'h0000_03E8, 1'b0);
        wr(`ACP_REG_CTRL, ctl(3'h4, 1'b1, 2'h0, 7'h32), 1'b0);
        rchk(`ACP_REG_BW, 32'h0000_01F4);
        wr(`ACP_REG_CTRL, ctl(3'h5, 1'b1, 2'h0, 7'h64), 1'b0);
        wr(`ACP_REG_SCR, 32'h0001_86A0, 1'b0);
        wr(`ACP_REG_PCR, {8'h00, `ACP_LINE_RST}, 1'b0);
        wr(`ACP_REG_CTRL, ctl(3'h4, 1'b0, 2'h0, 7'h64), 1'b0);
        wr(`ACP_REG_SCR, 32'h0000_0005, 1'b1);
        rchk(12'h100, 32'h0);
        check("unmapped err", {31'h0, rerr}, 32'h1);
        idle();
        cells(4'h3, 1'b0, 8'h00, {P0, DR, DR});
        cells(4'h1, 1'b0, 8'h4B, {P0, DR, DR});
        cells(4'h1, 1'b0, 8'h4B, {P0, DR, DR});
        wr(`ACP_REG_CDVT, 32'h0000_0002, 1'b0);
        wr(`ACP_REG_CTRL, ctl(3'h4, 1'b0, 2'h0, 7'h64), 1'b0);
        idle();
        cells(4'h3, 1'b0, 8'h00, {P0, P0, DR});
        wr(`ACP_REG_CDVT, 32'h0, 1'b0);
        for (int i = 0; i < 5; i++) begin
            wr(`ACP_REG_MBS, {31'h0, ROWS[i][3]} + 32'h1, 1'b0);
            wr(`ACP_REG_CTRL, ctl(ROWS[i][6:4], 1'b0, 2'h0, 7'h64), 1'b0);
            idle();
            cells(4'h1, 1'b0, 8'h00, {P0, DR, DR});
            cells(4'h1, ROWS[i][2], 8'h4B, {ROWS[i][1:0], DR, DR});
        end
        cells(4'h1, 1'b0, 8'hC8, {P0, DR, DR});
        test_done();
    end
endmodule // testbench

`default_nettype wire
